// >>> include/acs_pkg.sv
// constants shared by the conversion sequencer files
package acs_pkg;

    // ==========================================================
    // register map, apb byte addresses
    localparam logic [7:0] CTRL_ADDR = 8'h00;
    localparam logic [7:0] SEL_ADDR = 8'h04;
    localparam logic [7:0] RESULT_ADDR = 8'h08;
    localparam logic [7:0] STATUS_ADDR = 8'h0C;

    // ==========================================================
    // control register fields
    localparam int DIV_LSB = 0;
    localparam int DONE_BIT = 4;
    localparam int AUTO_BIT = 5;
    localparam int START_BIT = 6;
    localparam int ENABLE_BIT = 7;
    localparam int FREE_BIT = 8;
    localparam int DIFF_BIT = 9;

    // selection register fields
    localparam int CHAN_LSB = 0;
    localparam int REF_LSB = 5;

    // ==========================================================
    // reset values
    localparam logic [9:0] CTRL_RESET = 10'h000;
    localparam logic [6:0] SEL_RESET = 7'h00;

    // ==========================================================
    // conversion lengths in converter cycles, doubled to count half cycles
    localparam logic [5:0] NORMAL_HALVES = 6'h1A;
    localparam logic [5:0] FIRST_HALVES = 6'h32;
    localparam logic [5:0] AUTO_HALVES = 6'h1B;
    localparam logic [5:0] DIFF_LONG_HALVES = 6'h1C;
    // sample points in half cycles
    localparam logic [5:0] NORMAL_SAMPLE = 6'h03;
    localparam logic [5:0] FIRST_SAMPLE = 6'h1B;
    localparam logic [5:0] AUTO_SAMPLE = 6'h04;
    // cpu cycles spent synchronising the trigger
    localparam int TRIG_SYNC_CYCLES = 3;

    // state of the sequencer
    typedef enum logic [1:0] {IDLE, WAIT_EDGE, CONVERT} acs_state_type;

endpackage : acs_pkg

// >>> src/acs_prescaler.sv
// prescaler that makes converter half-cycle ticks from the cpu clock
`timescale 1ns/1ps
module acs_prescaler (
    input wire logic mclk,
    input wire logic clear,
    input wire logic [2:0] divSelect,
    output logic halfTick,
    output logic convPhase
);
    logic [6:0] count_reg;
    logic [6:0] halfLimit;

    // power-of-two division ratios
    // half of the division ratio; codes 0 and 1 both divide by two
    always_comb begin
        halfLimit = (divSelect == 3'h0) ? 7'h01 : 7'(7'h01 << (divSelect - 3'h1));
    end

    // counter held in clear while disabled or at a trigger
    always_ff @(posedge mclk) begin
        if (clear) begin
            count_reg <= 7'h00;
            halfTick <= 1'b0;
            convPhase <= 1'b0;
        end else if (count_reg + 7'h01 >= halfLimit) begin
            count_reg <= 7'h00;
            halfTick <= 1'b1;
            convPhase <= ~convPhase;
        end else begin
            count_reg <= count_reg + 7'h01;
            halfTick <= 1'b0;
        end
    end
endmodule : acs_prescaler

// >>> src/acs_sequencer.sv
// conversion sequencer with apb registers, trigger sync and timing
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
// Contract
// - prescaler held in reset while disabled
// - software start begins at next converter edge
// - normal 13 cycles, first 25 cycles
// - sample at 1.5 or 13.5 cycles
// - done stores result, sets flag, clears start
// - trigger resets prescaler, sample at two
// - trigger passes three-cycle synchroniser
// - free running restarts, start stays high
// - differential aligns to half-rate clock, 13/14
// - free running differential restarts take 14
// - selection copied until start, then locked
// - copying resumes in last converter cycle
// - free-running change affects conversion after next
// - start bit reads one while converting
// - retrigger ignored, held trigger no restart
module acs_sequencer (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic triggerIn,
    input wire logic [9:0] coreResult,
    output logic sampleHold,
    output logic [4:0] channelSelect,
    output logic [1:0] referenceSelect,
    output logic half_rate_conv_clock,
    output logic conversionActive
);
    // ==========================================================
    // registers and state
    acs_pkg::acs_state_type state_reg;
    logic [2:0] clkDivSelect_reg;
    logic conversionDoneFlag_reg;
    logic autoTriggerEnable_reg;
    logic startConversion_reg;
    logic converterEnable_reg;
    logic freeRunning_reg;
    logic differential_reg;
    logic [6:0] selBuffer_reg;
    logic [9:0] result_reg;
    logic firstPending_reg;
    logic [5:0] halfCount_reg;
    logic [5:0] endCount_reg;
    logic [5:0] sampleAt_reg;
    logic trigMeta_reg;
    logic trigSync_reg;
    logic trigLast_reg;
    logic [2:0] trigPipe_reg;
    logic [31:0] prdata_next;

    logic halfTick;
    logic convPhase;
    logic prescClear;
    logic risingEdge;
    logic trigLaunch;
    logic wrCtrl;
    logic wrSel;
    logic finishNow;
    logic lastCycle;
    logic swStart;

    // ==========================================================
    // bus decode; one wait-free access phase
    assign wrCtrl = psel && penable && pwrite && (paddr == acs_pkg::CTRL_ADDR);
    assign wrSel = psel && penable && pwrite && (paddr == acs_pkg::SEL_ADDR);
    assign swStart = wrCtrl && pwdata[acs_pkg::START_BIT] && pwdata[acs_pkg::ENABLE_BIT];

    // decide whether an address is mapped
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == acs_pkg::CTRL_ADDR) || (a == acs_pkg::SEL_ADDR)
            || (a == acs_pkg::RESULT_ADDR) || (a == acs_pkg::STATUS_ADDR);
    endfunction : mapped

    // read mux
    always_comb begin
        prdata_next = 32'h0000_0000;
        unique case (paddr)
            acs_pkg::CTRL_ADDR: begin
                prdata_next[2:0] = clkDivSelect_reg;
                prdata_next[acs_pkg::DONE_BIT] = conversionDoneFlag_reg;
                prdata_next[acs_pkg::AUTO_BIT] = autoTriggerEnable_reg;
                prdata_next[acs_pkg::START_BIT] = startConversion_reg
                    || (state_reg != acs_pkg::IDLE);
                prdata_next[acs_pkg::ENABLE_BIT] = converterEnable_reg;
                prdata_next[acs_pkg::FREE_BIT] = freeRunning_reg;
                prdata_next[acs_pkg::DIFF_BIT] = differential_reg;
            end
            acs_pkg::SEL_ADDR: prdata_next[6:0] = selBuffer_reg;
            acs_pkg::RESULT_ADDR: prdata_next[9:0] = result_reg;
            acs_pkg::STATUS_ADDR: begin
                prdata_next[1:0] = state_reg;
                prdata_next[13:8] = halfCount_reg;
            end
            default: prdata_next = 32'h0000_0000;
        endcase
    end

    // answer in the access phase; error on unmapped addresses
    always_ff @(posedge mclk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
            prdata <= prdata_next;
        end
    end

    // ==========================================================
    // software control bits
    always_ff @(posedge mclk) begin
        if (reset) begin
            clkDivSelect_reg <= acs_pkg::CTRL_RESET[2:0];
            autoTriggerEnable_reg <= 1'b0;
            converterEnable_reg <= 1'b0;
            freeRunning_reg <= 1'b0;
            differential_reg <= 1'b0;
            selBuffer_reg <= acs_pkg::SEL_RESET;
        end else begin
            if (wrCtrl) begin
                clkDivSelect_reg <= pwdata[acs_pkg::DIV_LSB +: 3];
                autoTriggerEnable_reg <= pwdata[acs_pkg::AUTO_BIT];
                converterEnable_reg <= pwdata[acs_pkg::ENABLE_BIT];
                freeRunning_reg <= pwdata[acs_pkg::FREE_BIT];
                differential_reg <= pwdata[acs_pkg::DIFF_BIT];
            end
            if (wrSel) begin
                selBuffer_reg <= pwdata[6:0];
            end
        end
    end

    // ==========================================================
    // three-cycle trigger sync
    // two flops for the pin, then the edge pulse runs down a pipe
    always_ff @(posedge mclk) begin
        if (reset) begin
            trigMeta_reg <= 1'b0;
            trigSync_reg <= 1'b0;
            trigLast_reg <= 1'b0;
            trigPipe_reg <= 3'h0;
        end else begin
            trigMeta_reg <= triggerIn;
            trigSync_reg <= trigMeta_reg;
            trigLast_reg <= trigSync_reg;
            trigPipe_reg <= {trigPipe_reg[1:0], risingEdge};
        end
    end
    assign risingEdge = trigSync_reg && !trigLast_reg;
    assign trigLaunch = trigPipe_reg[acs_pkg::TRIG_SYNC_CYCLES - 1] && autoTriggerEnable_reg
        && converterEnable_reg && (state_reg == acs_pkg::IDLE);

    // ==========================================================
    // prescaler clear while disabled
    assign prescClear = !converterEnable_reg || trigLaunch;

    acs_prescaler prescaler (
        .mclk(mclk),
        .clear(prescClear),
        .divSelect(clkDivSelect_reg),
        .halfTick(halfTick),
        .convPhase(convPhase)
    );

    // ==========================================================
    // type-specific completion count
    assign finishNow = (state_reg == acs_pkg::CONVERT) && halfTick
        && (halfCount_reg + 6'h01 >= endCount_reg);
    assign lastCycle = (state_reg == acs_pkg::CONVERT) && (halfCount_reg + 6'h02 >= endCount_reg);

    // sequencer; counts half converter cycles so the 0.5 points land on edges
    always_ff @(posedge mclk) begin
        if (reset || !converterEnable_reg) begin
            state_reg <= acs_pkg::IDLE;
            halfCount_reg <= 6'h00;
            endCount_reg <= acs_pkg::NORMAL_HALVES;
            sampleAt_reg <= acs_pkg::NORMAL_SAMPLE;
            firstPending_reg <= 1'b1;
        end else begin
            unique case (state_reg)
                acs_pkg::IDLE: begin
                    if (trigLaunch) begin
                        state_reg <= acs_pkg::CONVERT;
                        halfCount_reg <= 6'h00;
                        endCount_reg <= firstPending_reg ? acs_pkg::FIRST_HALVES
                            : acs_pkg::AUTO_HALVES;
                        sampleAt_reg <= firstPending_reg ? acs_pkg::FIRST_SAMPLE
                            : acs_pkg::AUTO_SAMPLE;
                    end else if (swStart || startConversion_reg) begin
                        state_reg <= acs_pkg::WAIT_EDGE;
                    end
                end
                acs_pkg::WAIT_EDGE: begin
                    if (halfTick && convPhase == 1'b0) begin
                        state_reg <= acs_pkg::CONVERT;
                        halfCount_reg <= 6'h00;
                        if (firstPending_reg) begin
                            endCount_reg <= acs_pkg::FIRST_HALVES;
                            sampleAt_reg <= acs_pkg::FIRST_SAMPLE;
                        end else if (differential_reg && half_rate_conv_clock) begin
                            endCount_reg <= acs_pkg::DIFF_LONG_HALVES;
                            sampleAt_reg <= acs_pkg::NORMAL_SAMPLE + 6'h02;
                        end else begin
                            endCount_reg <= acs_pkg::NORMAL_HALVES;
                            sampleAt_reg <= acs_pkg::NORMAL_SAMPLE;
                        end
                    end
                end
                acs_pkg::CONVERT: begin
                    if (halfTick) begin
                        halfCount_reg <= halfCount_reg + 6'h01;
                    end
                    if (finishNow) begin
                        firstPending_reg <= 1'b0;
                        halfCount_reg <= 6'h00;
                        if (freeRunning_reg) begin
                            endCount_reg <= differential_reg ? acs_pkg::DIFF_LONG_HALVES
                                : acs_pkg::NORMAL_HALVES;
                            sampleAt_reg <= differential_reg ? acs_pkg::NORMAL_SAMPLE + 6'h02
                                : acs_pkg::NORMAL_SAMPLE;
                        end else begin
                            state_reg <= acs_pkg::IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ==========================================================
    // start cleared at completion unless free running
    // set by software wins over the hardware clear in the same cycle
    always_ff @(posedge mclk) begin
        if (reset) begin
            startConversion_reg <= 1'b0;
        end else if (swStart) begin
            startConversion_reg <= 1'b1;
        end else if (!converterEnable_reg || (finishNow && !freeRunning_reg)) begin
            startConversion_reg <= 1'b0;
        end else if (trigLaunch) begin
            startConversion_reg <= 1'b1;
        end
    end

    // result stored and flag set; writing one clears, set wins
    always_ff @(posedge mclk) begin
        if (reset) begin
            conversionDoneFlag_reg <= 1'b0;
            result_reg <= 10'h000;
        end else if (finishNow) begin
            conversionDoneFlag_reg <= 1'b1;
            result_reg <= coreResult;
        end else if (wrCtrl && pwdata[acs_pkg::DONE_BIT]) begin
            conversionDoneFlag_reg <= 1'b0;
        end
    end

    // ==========================================================
    // selection locked during conversion
    // free-running change lands one conversion late
    always_ff @(posedge mclk) begin
        if (reset) begin
            channelSelect <= acs_pkg::SEL_RESET[4:0];
            referenceSelect <= acs_pkg::SEL_RESET[6:5];
        end else if (state_reg != acs_pkg::CONVERT || lastCycle) begin
            channelSelect <= selBuffer_reg[acs_pkg::CHAN_LSB +: 5];
            referenceSelect <= selBuffer_reg[acs_pkg::REF_LSB +: 2];
        end
    end

    // sample strobe at 1.5, 2, 2.5 or 13.5
    // analog outputs and the half-rate clock
    always_ff @(posedge mclk) begin
        if (reset) begin
            sampleHold <= 1'b0;
            conversionActive <= 1'b0;
            half_rate_conv_clock <= 1'b0;
        end else begin
            sampleHold <= (state_reg == acs_pkg::CONVERT) && halfTick
                && (halfCount_reg + 6'h01 == sampleAt_reg);
            conversionActive <= ((state_reg == acs_pkg::CONVERT) && !finishNow)
                || ((state_reg == acs_pkg::WAIT_EDGE) && halfTick && !convPhase) || trigLaunch;
            if (!converterEnable_reg) begin
                half_rate_conv_clock <= 1'b0;
            end else if (halfTick && convPhase == 1'b0) begin
                half_rate_conv_clock <= ~half_rate_conv_clock;
            end
        end
    end

endmodule : acs_sequencer

// >>> testbench/acs_seq_chk.sv
// port assertions for the conversion sequencer
`timescale 1ns/1ps
module acs_seq_chk (
    input wire logic mclk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sampleHold,
    input wire logic [4:0] channelSelect,
    input wire logic conversionActive
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // ==========================================================
    // decode of the four mapped words
    logic mapped;
    assign mapped = paddr inside {acs_pkg::CTRL_ADDR, acs_pkg::SEL_ADDR,
        acs_pkg::RESULT_ADDR, acs_pkg::STATUS_ADDR};
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable;
    endsequence
    // ==========================================================
    // bus answer timing
    a_ready_after_setup: assert property (setup_s |=> access_s ##0 pready)
        else $error("no answer in access phase");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_ready_in_access: assert property (pready |-> access_s)
        else $error("ready outside access");
    a_err_unmapped: assert property (access_s ##0 pready && !mapped |-> pslverr)
        else $error("unmapped access accepted");
    a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    // ==========================================================
    // conversion timing and selection lock
    a_sample_pulse: assert property (sampleHold |=> !sampleHold)
        else $error("sample strobe too long");
    a_sample_active: assert property (sampleHold |-> conversionActive)
        else $error("sample outside conversion");
    a_select_locked: assert property ($rose(conversionActive) |=>
        $stable(channelSelect) [*8]) else $error("selection moved early");
endmodule : acs_seq_chk

// >>> testbench/acs_core_model.sv
// behavioural analog core returning a channel-tagged code
`timescale 1ns/1ps
module acs_core_model (
    input wire logic mclk,
    input wire logic reset,
    input wire logic sampleHold,
    input wire logic [4:0] channelSelect,
    output logic [9:0] coreResult
);
    // ==========================================================
    // code fixed at the sample point, so a wrong lock shows in the result
    always_ff @(posedge mclk) begin
        if (reset) begin
            coreResult <= 10'h3FF;
        end else if (sampleHold) begin
            coreResult <= {5'h14, channelSelect};
        end
    end
endmodule : acs_core_model

// >>> testbench/tb.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module tb;
    localparam logic [31:0] EN = 32'h1 << acs_pkg::ENABLE_BIT;
    localparam logic [31:0] ST = 32'h1 << acs_pkg::START_BIT;
    localparam logic [31:0] DN = 32'h1 << acs_pkg::DONE_BIT;
    localparam logic [31:0] AU = 32'h1 << acs_pkg::AUTO_BIT;
    localparam logic [31:0] FR = 32'h1 << acs_pkg::FREE_BIT;
    localparam logic [31:0] DF = 32'h1 << acs_pkg::DIFF_BIT;
    logic mclk, reset, psel, penable, pwrite, pready, pslverr, triggerIn, rerr;
    logic sampleHold, half_rate_conv_clock, conversionActive;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0] coreResult;
    logic [4:0] channelSelect;
    logic [1:0] referenceSelect;
    int err_total = 0, checks = 0, runLen = 0, lastLen = 0, lastSamp = 0;
    acs_sequencer dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .triggerIn(triggerIn),
        .coreResult(coreResult), .sampleHold(sampleHold), .channelSelect(channelSelect),
        .referenceSelect(referenceSelect), .half_rate_conv_clock(half_rate_conv_clock),
        .conversionActive(conversionActive));
    acs_core_model core (.mclk(mclk), .reset(reset), .sampleHold(sampleHold),
        .channelSelect(channelSelect), .coreResult(coreResult));
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // length and sample offset of each finished conversion, in mclk cycles
    always @(negedge mclk) begin
        if (conversionActive === 1'b1) begin
            if (sampleHold === 1'b1) lastSamp <= runLen;
            runLen <= runLen + 1;
        end else if (runLen != 0) begin
            lastLen <= runLen;
            runLen <= 0;
        end
    end
    // ==========================================================
    // reporting
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize
    task automatic check32(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t got %h expected %h", $time, got, exp);
        end
    endtask : check32
    task automatic timeout();
        err_total++;
        $display("Error %0t wait ran out", $time);
        summarize();
    endtask : timeout
    // ==========================================================
    // apb master: request held until ready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
            if (n > 20) timeout();
        end while (pready !== 1'b1);
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check32(rd, exp);
    endtask : rdchk
    task automatic wait_done();
        int n;
        n = 0;
        while (conversionActive !== 1'b1) begin
            @(negedge mclk);
            if (++n > 2000) timeout();
        end
        while (conversionActive !== 1'b0) begin
            @(negedge mclk);
            if (++n > 2000) timeout();
        end
        @(negedge mclk);
    endtask : wait_done
    task automatic wait_sample(output int c);
        c = 0;
        do begin
            @(negedge mclk);
            if (++c > 500) timeout();
        end while (sampleHold !== 1'b1);
    endtask : wait_sample
    task automatic count_samples(input int cyc, inout int k);
        repeat (cyc) begin
            @(negedge mclk);
            if (sampleHold === 1'b1) k++;
        end
    endtask : count_samples
    // ==========================================================
    // scenarios
    task automatic t_reset();
        rdchk(acs_pkg::CTRL_ADDR, 32'h0);
        rdchk(acs_pkg::SEL_ADDR, 32'h0);
        rdchk(8'h10, 32'h0);
        check32({31'h0, rerr}, 32'h1);
    endtask : t_reset
    task automatic t_single();
        apb(1'b1, acs_pkg::SEL_ADDR, 32'h3);
        apb(1'b1, acs_pkg::CTRL_ADDR, EN | ST);
        rdchk(acs_pkg::CTRL_ADDR, EN | ST);
        wait_done();
        check32(lastLen, 32'(acs_pkg::FIRST_HALVES));
        check32(lastSamp, 32'(acs_pkg::FIRST_SAMPLE));
        rdchk(acs_pkg::CTRL_ADDR, EN | DN);
        rdchk(acs_pkg::RESULT_ADDR, {22'h0, 5'h14, 5'h03});
        apb(1'b1, acs_pkg::CTRL_ADDR, EN | ST | DN | 32'h2);
        wait_done();
        check32(lastLen, 32'(acs_pkg::NORMAL_HALVES) * 2);
        check32(lastSamp, 32'(acs_pkg::NORMAL_SAMPLE) * 2);
    endtask : t_single
    task automatic t_free(input logic diff);
        int c;
        apb(1'b1, acs_pkg::CTRL_ADDR, 32'h0);
        apb(1'b1, acs_pkg::SEL_ADDR, 32'h5);
        apb(1'b1, acs_pkg::CTRL_ADDR, EN | ST | FR | (diff ? DF : 32'h0));
        wait_sample(c);
        wait_sample(c);
        check32({27'h0, channelSelect}, 32'h5);
        // reselect long after the start write
        // no settling needed by the model core
        apb(1'b1, acs_pkg::SEL_ADDR, 32'h9);
        rdchk(acs_pkg::CTRL_ADDR, EN | ST | FR | DN | (diff ? DF : 32'h0));
        wait_sample(c);
        check32({27'h0, channelSelect}, 32'h9);
        wait_sample(c);
        check32(c, diff ? 32'(acs_pkg::DIFF_LONG_HALVES) : 32'(acs_pkg::NORMAL_HALVES));
        apb(1'b1, acs_pkg::CTRL_ADDR, 32'h0);
    endtask : t_free
    task automatic t_auto();
        int k;
        k = 0;
        // divider kept at one fixed ratio
        apb(1'b1, acs_pkg::CTRL_ADDR, EN | AU);
        @(posedge mclk) triggerIn <= 1'b1;
        count_samples(10, k);
        @(posedge mclk) triggerIn <= 1'b0;
        count_samples(10, k);
        @(posedge mclk) triggerIn <= 1'b1;
        count_samples(150, k);
        check32(k, 32'h1);
        @(posedge mclk) triggerIn <= 1'b0;
        count_samples(10, k);
        @(posedge mclk) triggerIn <= 1'b1;
        count_samples(100, k);
        check32(k, 32'h2);
        @(posedge mclk) triggerIn <= 1'b0;
    endtask : t_auto
    initial begin
        reset = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        triggerIn = 1'b0;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_single();
        t_free(1'b0);
        t_free(1'b1);
        t_auto();
        summarize();
    end
endmodule : tb
bind acs_sequencer acs_seq_chk chk (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sampleHold(sampleHold),
    .channelSelect(channelSelect), .conversionActive(conversionActive));
